// File: rtl/mfrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfrs_defines.svh"
module mfrs_sequencer import mfrs_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flashCsN,
  input wire logic flashSclk,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic quadLinesEnable,
  output logic memReq,
  output logic [23:0] memAddr,
  input wire logic memAck,
  input wire logic [7:0] memData,
  output logic [2:0] wrapSettingBits,
  output logic continuousActive
);
  localparam mfrs_regs_s RST_VAL = '{
    sclkSync: 2'h0, csSync: 2'h3, ioSync: 8'h00, sclkPrev: 1'b0,
    state: ST_IDLE, kind: KD_DUAL, cnt: 6'h00, shiftIn: 24'h000000,
    cont: 1'b0, contKind: KD_DUAL, wrapBits: `MFRS_WRAP_RESET,
    fetching: 1'b0, req: 1'b0, stale: 1'b0, addr: 24'h000000,
    outByte: 8'h00, beat: 2'h0, ioOut: 4'h0, ioOe: 4'h0
  };

  mfrs_regs_s st;
  mfrs_regs_s next_st;

  logic sclkNow;
  logic riseEv;
  logic fallEv;
  logic csLow;
  logic [3:0] ioNow;
  logic isDual;
  logic [23:0] shiftNext;
  logic [7:0] opcode;
  logic [5:0] addrLast;
  logic [5:0] modeLast;
  logic [5:0] dummyLast;
  logic modeDone;
  logic opDone;
  logic wrapDone;
  logic [1:0] modePair;
  logic [2:0] wrapNew;
  logic [7:0] secMask;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] fifoOutData;
  logic [7:0] dataSrc;

  // ==========================================================
  // address step, confined to the wrap section when enabled
  function automatic logic [23:0] stepAddr(input logic [23:0] a, input logic [2:0] w);
    logic [7:0] m;
    logic [7:0] lo;
    m = (`MFRS_SECTION_MIN << w[2:1]) - 8'h01;
    lo = a[7:0] + 8'h01;
    if (w[0]) begin
      stepAddr = a + 24'h000001;
    end else begin
      stepAddr = {a[23:8], (a[7:0] & ~m) | (lo & m)};
    end
  endfunction

  // ==========================================================
  // synchronised pin views and link clock edges
  assign sclkNow = st.sclkSync[1];
  assign riseEv = sclkNow & ~st.sclkPrev;
  assign fallEv = ~sclkNow & st.sclkPrev;
  assign csLow = ~st.csSync[1];
  assign ioNow = st.ioSync[7:4];
  assign isDual = (st.kind == KD_DUAL);

  // lane-wide shift and phase lengths
  assign shiftNext = isDual ? {st.shiftIn[21:0], ioNow[1:0]} : {st.shiftIn[19:0], ioNow};
  assign opcode = {st.shiftIn[6:0], ioNow[0]};
  assign addrLast = isDual ? `MFRS_ADDR_LAST_DUAL : `MFRS_ADDR_LAST_QUAD;
  assign modeLast = isDual ? `MFRS_MODE_LAST_DUAL : `MFRS_MODE_LAST_QUAD;
  assign dummyLast = (st.kind == KD_WORD) ? `MFRS_DUMMY_LAST_WORD : `MFRS_DUMMY_LAST_QUAD;

  // phase completion strobes
  assign modeDone = (st.state == ST_MODE) && riseEv && (st.cnt == modeLast);
  assign opDone = (st.state == ST_CMD) && riseEv && (st.cnt == `MFRS_OP_LAST);
  assign wrapDone = (st.state == ST_WRAP) && riseEv && (st.cnt == `MFRS_WRAP_LAST);
  assign modePair = shiftNext[5:4];
  assign wrapNew = {shiftNext[6:5], shiftNext[4]};
  assign secMask = (`MFRS_SECTION_MIN << st.wrapBits[2:1]) - 8'h01;

  // queue hand-off: push fresh array bytes, pop on each byte start
  assign fifoInValid = memAck & st.req & ~st.stale & st.fetching;
  assign fifoOutReady = (st.state == ST_DATA) && fallEv && (st.beat == 2'h0) && csLow;
  assign dataSrc = (st.beat != 2'h0) ? st.outByte : (fifoOutValid ? fifoOutData : 8'h00);

  // ==========================================================
  // byte queue in the data path
  mfrs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .flush(~csLow),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(memData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st = st;
    next_st.sclkSync = {st.sclkSync[0], flashSclk};
    next_st.csSync = {st.csSync[0], flashCsN};
    next_st.ioSync = {st.ioSync[3:0], ioIn};
    next_st.sclkPrev = st.sclkSync[1];

    // array fetch: one request in flight, only while the queue has room
    if (st.req && memAck) begin
      next_st.req = 1'b0;
      next_st.stale = 1'b0;
      if (!st.stale && st.fetching) begin
        // dual reads never wrap; the setting belongs to quad and word reads
        next_st.addr = stepAddr(st.addr, st.wrapBits | {2'b00, isDual});
      end
    end else if (st.fetching && !st.req && fifoInReady) begin
      next_st.req = 1'b1;
    end

    // frame sequencing
    unique case (st.state)
      ST_IDLE: begin
        if (csLow) begin
          next_st.cnt = 6'h00;
          if (st.cont) begin
            next_st.state = ST_ADDR;
            next_st.kind = st.contKind;
          end else begin
            next_st.state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (riseEv) begin
          next_st.shiftIn = {st.shiftIn[22:0], ioNow[0]};
          next_st.cnt = st.cnt + 6'h01;
          if (opDone) begin
            next_st.cnt = 6'h00;
            next_st.state = ST_SKIP;
            unique case (opcode)
              `MFRS_OP_DUAL: begin
                next_st.state = ST_ADDR;
                next_st.kind = KD_DUAL;
              end
              `MFRS_OP_QUAD: begin
                if (quadLinesEnable) begin
                  next_st.state = ST_ADDR;
                  next_st.kind = KD_QUAD;
                end
              end
              `MFRS_OP_WORD: begin
                if (quadLinesEnable) begin
                  next_st.state = ST_ADDR;
                  next_st.kind = KD_WORD;
                end
              end
              `MFRS_OP_WRAP: begin
                next_st.state = ST_WRAP;
                next_st.kind = KD_QUAD;
              end
              `MFRS_OP_MODE_RESET: next_st.cont = 1'b0;
              default: next_st.state = ST_SKIP;
            endcase
          end
        end
      end
      ST_ADDR: begin
        if (riseEv) begin
          next_st.shiftIn = shiftNext;
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == addrLast) begin
            next_st.addr = shiftNext;
            next_st.fetching = 1'b1;
            next_st.cnt = 6'h00;
            next_st.state = ST_MODE;
          end
        end
      end
      ST_MODE: begin
        if (riseEv) begin
          next_st.shiftIn = shiftNext;
          next_st.cnt = st.cnt + 6'h01;
          if (modeDone) begin
            // only the continuation pair decides; all-ones also resets
            next_st.cont = (modePair == `MFRS_CONT_PAIR);
            next_st.contKind = st.kind;
            next_st.cnt = 6'h00;
            next_st.beat = 2'h0;
            next_st.state = isDual ? ST_DATA : ST_DUMMY;
          end
        end
      end
      ST_DUMMY: begin
        if (riseEv) begin
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == dummyLast) begin
            next_st.state = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        // new lanes appear after each falling link edge
        if (fallEv) begin
          if (isDual) begin
            next_st.ioOut = {2'b00, dataSrc[7:6]};
            next_st.outByte = {dataSrc[5:0], 2'b00};
            next_st.ioOe = `MFRS_OE_DUAL;
          end else begin
            next_st.ioOut = dataSrc[7:4];
            next_st.outByte = {dataSrc[3:0], 4'h0};
            next_st.ioOe = `MFRS_OE_QUAD;
          end
          if (st.beat == 2'h0) begin
            next_st.beat = isDual ? `MFRS_BEAT_LAST_DUAL : `MFRS_BEAT_LAST_QUAD;
          end else begin
            next_st.beat = st.beat - 2'h1;
          end
        end
      end
      ST_WRAP: begin
        if (riseEv) begin
          next_st.shiftIn = shiftNext;
          next_st.cnt = st.cnt + 6'h01;
          if (wrapDone) begin
            next_st.wrapBits = wrapNew;
            next_st.state = ST_SKIP;
          end
        end
      end
      ST_SKIP: begin
        next_st.cnt = 6'h00;
      end
      default: next_st = RST_VAL;
    endcase

    // deselect ends every frame; a late array answer is discarded
    if (!csLow) begin
      next_st.state = ST_IDLE;
      next_st.ioOe = 4'h0;
      next_st.fetching = 1'b0;
      next_st.beat = 2'h0;
      next_st.cnt = 6'h00;
      if (st.req && !memAck) begin
        next_st.stale = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign ioOut = st.ioOut;
  assign ioOe = st.ioOe;
  assign memReq = st.req;
  assign memAddr = st.addr;
  assign wrapSettingBits = st.wrapBits;
  assign continuousActive = st.cont;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_mode_keep;
    modeDone && csLow && (modePair == `MFRS_CONT_PAIR);
  endsequence
  sequence s_mode_drop;
    modeDone && csLow && (modePair != `MFRS_CONT_PAIR);
  endsequence
  sequence s_array_step;
    memAck && st.req && !st.stale && st.fetching && csLow;
  endsequence

  a_cont_enter: assert property (s_mode_keep |=> st.cont)
    else $error("pair 10 did not keep continuous mode");
  a_cont_exit: assert property (s_mode_drop |=> !st.cont ##1 (st.state != ST_ADDR))
    else $error("pair not 10 left continuous mode set");
  a_cont_skip: assert property ((st.state == ST_IDLE) && csLow && st.cont
      |=> (st.state == ST_ADDR) && (st.kind == $past(st.contKind)))
    else $error("continuous frame did not start at address");
  a_quad_gate: assert property (opDone && (opcode == `MFRS_OP_QUAD) && !quadLinesEnable
      |=> st.state inside {ST_SKIP, ST_IDLE})
    else $error("quad read accepted with quad lines off");
  a_word_gate: assert property (opDone && (opcode == `MFRS_OP_WORD) && !quadLinesEnable
      |=> st.state inside {ST_SKIP, ST_IDLE})
    else $error("word read accepted with status bit nine off");
  a_linear_step: assert property (s_array_step ##0 (st.wrapBits[0] || isDual)
      |=> memAddr == $past(memAddr) + 24'h000001)
    else $error("linear address did not advance by one");
  a_wrap_section: assert property (s_array_step ##0 (!st.wrapBits[0] && !isDual)
      |=> (memAddr[23:8] == $past(memAddr[23:8])) &&
          ((memAddr[7:0] & ~$past(secMask)) == ($past(memAddr[7:0]) & ~$past(secMask))) &&
          ((memAddr[7:0] & $past(secMask)) == (($past(memAddr[7:0]) + 8'h01) & $past(secMask))))
    else $error("wrapped address left its section");
  a_wrap_store: assert property (wrapDone |=> wrapSettingBits == $past(wrapNew))
    else $error("wrap setting not stored");
  a_wrap_reset: assert property ($fell(rst) |-> wrapSettingBits[0])
    else $error("wrap not off after reset");
  a_dual_lanes: assert property ((st.state == ST_DATA) && isDual && fallEv && csLow
      |=> ioOe == `MFRS_OE_DUAL)
    else $error("dual data not on two lanes");
  a_quad_dummy: assert property ((st.state == ST_DUMMY) && (st.kind == KD_QUAD) &&
      riseEv && csLow && (st.cnt == `MFRS_DUMMY_LAST_QUAD) |=> st.state == ST_DATA)
    else $error("quad read dummy count wrong");
  a_word_dummy: assert property ((st.state == ST_DUMMY) && (st.kind == KD_WORD) &&
      riseEv && csLow && (st.cnt == `MFRS_DUMMY_LAST_WORD) |=> st.state == ST_DATA)
    else $error("word read dummy count wrong");
endmodule
`default_nettype wire

// File: inc/mfrs_defines.svh
`ifndef MFRS_DEFINES_SVH
`define MFRS_DEFINES_SVH
// ==========================================================
// opcodes
`define MFRS_OP_DUAL 8'hBB
`define MFRS_OP_QUAD 8'hEB
`define MFRS_OP_WORD 8'hE7
`define MFRS_OP_WRAP 8'h77
`define MFRS_OP_MODE_RESET 8'hFF
// ==========================================================
// continuation pair value that keeps continuous mode
`define MFRS_CONT_PAIR 2'h2
// ==========================================================
// last clock index of each phase (clocks minus one)
`define MFRS_OP_LAST 6'h07
`define MFRS_ADDR_LAST_DUAL 6'h0B
`define MFRS_ADDR_LAST_QUAD 6'h05
`define MFRS_MODE_LAST_DUAL 6'h03
`define MFRS_MODE_LAST_QUAD 6'h01
`define MFRS_DUMMY_LAST_QUAD 6'h03
`define MFRS_DUMMY_LAST_WORD 6'h01
`define MFRS_WRAP_LAST 6'h07
// ==========================================================
// wrap setting: {wrap_length_field, wrap_off_bit}, off after reset
`define MFRS_WRAP_RESET 3'h1
`define MFRS_SECTION_MIN 8'h08
// ==========================================================
// output lanes and last beat index of each byte (beats minus one)
`define MFRS_OE_DUAL 4'h3
`define MFRS_OE_QUAD 4'hF
`define MFRS_BEAT_LAST_DUAL 2'h3
`define MFRS_BEAT_LAST_QUAD 2'h1
`endif

// File: inc/mfrs_pkg.sv
package mfrs_pkg;
  // ==========================================================
  // sequencer phases, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DATA = 8'h20,
    ST_WRAP = 8'h40,
    ST_SKIP = 8'h80
  } mfrs_state_e;

  // ==========================================================
  // read flavours, one-hot
  typedef enum logic [2:0] {
    KD_DUAL = 3'h1,
    KD_QUAD = 3'h2,
    KD_WORD = 3'h4
  } mfrs_kind_e;

  // ==========================================================
  // complete sequencer state
  typedef struct packed {
    logic [1:0] sclkSync;
    logic [1:0] csSync;
    logic [7:0] ioSync;
    logic sclkPrev;
    mfrs_state_e state;
    mfrs_kind_e kind;
    logic [5:0] cnt;
    logic [23:0] shiftIn;
    logic cont;
    mfrs_kind_e contKind;
    logic [2:0] wrapBits;
    logic fetching;
    logic req;
    logic stale;
    logic [23:0] addr;
    logic [7:0] outByte;
    logic [1:0] beat;
    logic [3:0] ioOut;
    logic [3:0] ioOe;
  } mfrs_regs_s;
endpackage

// File: rtl/mfrs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// small byte queue between array fetch and serializer
module mfrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [PW:0] count;
  } mfrs_fifo_s;

  mfrs_fifo_s st;
  mfrs_fifo_s next_st;
  logic doPush;
  logic doPop;

  // honest flags from the occupancy count
  assign inReady = (st.count != FULL);
  assign outValid = (st.count != '0);
  assign outData = st.mem[st.rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // pointer and count update; flush empties without touching storage
  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    unique case ({doPush, doPop})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
    if (flush) begin
      next_st.rdPtr = '0;
      next_st.wrPtr = '0;
      next_st.count = '0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// File: test/mfrs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host flash controller model, clock parked low between frames
module mfrs_host_model (
  input wire logic ref_clk,
  input wire logic [3:0] pinIo,
  input wire logic [3:0] ioOe,
  output logic flashCsN,
  output logic flashSclk,
  output logic [3:0] hostIo
);
  logic [3:0] got;
  logic [3:0] lastOe;

  // idle levels: deselected, link clock still
  initial begin
    flashCsN = 1'b1;
    flashSclk = 1'b0;
    hostIo = 4'h0;
    got = 4'h0;
    lastOe = 4'h0;
  end

  // one link clock: lanes set while low, sampled mid-high; released lanes toggle
  task automatic tick(input logic [3:0] v, input logic [3:0] en);
    hostIo = (v & en) | (~hostIo & ~en);
    repeat (4) @(negedge ref_clk);
    flashSclk = 1'b1;
    repeat (2) @(negedge ref_clk);
    got = pinIo;
    lastOe = ioOe;
    repeat (2) @(negedge ref_clk);
    flashSclk = 1'b0;
  endtask

  // msb-first shift of nClk groups of lanes bits
  task automatic shift(input int lanes, input logic [31:0] val, input int nClk);
    logic [3:0] m;
    m = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
    for (int i = nClk - 1; i >= 0; i--) begin
      tick(4'((val >> (i * lanes)) & 32'(m)), m);
    end
  endtask

  // whole frame: opcode, address, mode byte, dummies, then read bytes
  task automatic frame(input logic [7:0] op, input logic withOp, input int lanes,
      input logic [23:0] addr, input logic [7:0] mode, input int dummies, input int nBytes,
      output logic [7:0] bytes [0:7]);
    logic [3:0] m;
    logic [7:0] b;
    m = (lanes == 4) ? 4'hF : 4'h3;
    flashCsN = 1'b0;
    repeat (4) @(negedge ref_clk);
    if (withOp) shift(1, {24'h000000, op}, 8);
    shift(lanes, {8'h00, addr}, 24 / lanes);
    shift(lanes, {24'h000000, mode}, 8 / lanes);
    for (int i = 0; i < dummies; i++) tick(4'h0, 4'h0);
    for (int n = 0; n < nBytes; n++) begin
      b = 8'h00;
      for (int i = 0; i < 8 / lanes; i++) begin
        tick(4'h0, 4'h0);
        b = 8'((b << lanes) | (got & m));
      end
      bytes[n] = b;
    end
    repeat (4) @(negedge ref_clk);
    flashCsN = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: test/tb_mfrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfrs_defines.svh"
// ==========================================================
// self-checking bench for the read sequencer
module tb_mfrs_sequencer;
  logic ref_clk;
  logic rst;
  logic flashCsN;
  logic flashSclk;
  logic [3:0] hostIo;
  logic [3:0] pinIo;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  logic quadLinesEnable;
  logic memReq;
  logic [23:0] memAddr;
  logic memAck;
  logic [7:0] memData;
  logic [2:0] wrapSettingBits;
  logic continuousActive;
  logic sawOe;
  logic [7:0] rd [0:7];
  logic [2:0] wrapNow;
  logic [7:0] op;
  logic [7:0] mode;
  logic [23:0] addr;
  logic [1:0] pair;
  int lanes;
  int dum;
  int sec;
  int mismatches;
  int testsRun;

  // pin level: device lanes where enabled, host elsewhere
  assign pinIo = (ioOe & ioOut) | (~ioOe & hostIo);

  mfrs_sequencer #(.FIFO_DEPTH(4)) uut (
    .ref_clk(ref_clk), .rst(rst), .flashCsN(flashCsN), .flashSclk(flashSclk),
    .ioIn(pinIo), .ioOut(ioOut), .ioOe(ioOe), .quadLinesEnable(quadLinesEnable),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData),
    .wrapSettingBits(wrapSettingBits), .continuousActive(continuousActive)
  );

  mfrs_host_model host (
    .ref_clk(ref_clk), .pinIo(pinIo), .ioOe(ioOe), .flashCsN(flashCsN),
    .flashSclk(flashSclk), .hostIo(hostIo)
  );

  // array contents as a function of the byte address
  function automatic logic [7:0] memFn(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction

  // address step, kept inside the section while wrapping
  function automatic logic [23:0] nextAddr(input logic [23:0] a, input logic [2:0] w);
    logic [23:0] m;
    m = 24'(8 << w[2:1]) - 24'h000001;
    if (w[0]) return a + 24'h000001;
    return (a & ~m) | ((a + 24'h000001) & m);
  endfunction

  task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBits(input string what, input logic [3:0] exp, input logic [3:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one read frame, bytes compared against stepped addresses
  task automatic readCheck(input logic [7:0] o, input logic withOp, input int ln,
      input logic [23:0] a0, input logic [7:0] md, input int dm, input int nBytes);
    logic [23:0] a;
    a = a0;
    host.frame(o, withOp, ln, a0, md, dm, nBytes, rd);
    for (int n = 0; n < nBytes; n++) begin
      chkByte("read byte", memFn(a), rd[n]);
      a = nextAddr(a, (ln == 2) ? 3'h1 : wrapNow);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // array responder with random stalls
  always @(negedge ref_clk) begin
    if (rst) begin
      memAck <= 1'b0;
      memData <= 8'h00;
    end else if (memReq && !memAck && ($urandom % 3 == 0)) begin
      memAck <= 1'b1;
      memData <= memFn(memAddr);
    end else begin
      memAck <= 1'b0;
    end
  end

  // notes any lane drive since reset
  always @(posedge ref_clk) begin
    if (rst) begin
      sawOe <= 1'b0;
    end else if (|ioOe) begin
      sawOe <= 1'b1;
    end
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    finalReport();
  end

  // main sequence
  initial begin
    void'($urandom(20354));
    rst = 1'b1;
    quadLinesEnable = 1'b0;
    wrapNow = 3'h1;
    mismatches = 0;
    testsRun = 0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chkBits("wrap bits", 4'h1, {1'b0, wrapSettingBits});
    chkBits("continuous", 4'h0, {3'h0, continuousActive});
    // quad reads refused while quad lanes disabled; drive flag cleared by reset
    host.frame(`MFRS_OP_QUAD, 1'b1, 4, 24'h000123, 8'h20, 4, 2, rd);
    host.frame(`MFRS_OP_WORD, 1'b1, 4, 24'h000124, 8'h20, 2, 2, rd);
    chkBits("refused drive", 4'h0, {3'h0, sawOe});
    chkBits("refused mode", 4'h0, {3'h0, continuousActive});
    quadLinesEnable = 1'b1;
    // each read kind: arm continuous mode, then leave it
    for (int k = 0; k < 3; k++) begin
      op = (k == 0) ? `MFRS_OP_DUAL : (k == 1) ? `MFRS_OP_QUAD : `MFRS_OP_WORD;
      lanes = (k == 0) ? 2 : 4;
      dum = (k == 0) ? 0 : (k == 1) ? 4 : 2;
      addr = 24'($urandom) & ((k == 2) ? 24'hFFFFFE : 24'hFFFFFF);
      mode = (8'($urandom) & 8'hCF) | 8'h20;
      readCheck(op, 1'b1, lanes, addr, mode, dum, 5);
      chkBits("lane enable", (lanes == 2) ? 4'h3 : 4'hF, host.lastOe);
      chkBits("continuous", 4'h1, {3'h0, continuousActive});
      pair = (k == 0) ? 2'h3 : 2'(k - 1);
      mode = (k == 0) ? 8'hFF : (8'($urandom) & 8'hCF) | {2'h0, pair, 4'h0};
      readCheck(op, 1'b0, lanes, 24'($urandom) & 24'hFFFFFE, mode, dum, 3);
      chkBits("continuous", 4'h0, {3'h0, continuousActive});
    end
    // every wrap length, read across the section end
    for (int len = 0; len < 4; len++) begin
      host.frame(`MFRS_OP_WRAP, 1'b1, 4, 24'($urandom), {1'b0, 2'(len), 1'b0, 4'($urandom)},
        0, 0, rd);
      wrapNow = {2'(len), 1'b0};
      chkBits("wrap bits", {1'b0, wrapNow}, {1'b0, wrapSettingBits});
      sec = 8 << len;
      addr = (24'($urandom) & ~24'(sec - 1)) | 24'(sec - 2);
      readCheck((len % 2 == 1) ? `MFRS_OP_WORD : `MFRS_OP_QUAD, 1'b1, 4, addr, 8'h00,
        (len % 2 == 1) ? 2 : 4, 6);
      // dual read stays linear even with wrapping on
      if (len == 0) readCheck(`MFRS_OP_DUAL, 1'b1, 2, addr, 8'h00, 0, 6);
    end
    // wrap switched off again, linear across the boundary
    host.frame(`MFRS_OP_WRAP, 1'b1, 4, 24'h000000, 8'h70, 0, 0, rd);
    wrapNow = 3'h7;
    chkBits("wrap bits", 4'h7, {1'b0, wrapSettingBits});
    readCheck(`MFRS_OP_QUAD, 1'b1, 4, 24'h012306, 8'h00, 4, 6);
    finalReport();
  end
endmodule
`default_nettype wire
